// File: logic/stats_defines.vh
// Constants for the per-port statistics counter block.
// Included by every design file of the block; definitions only.
`ifndef STATS_DEFINES_VH
`define STATS_DEFINES_VH

`define NUM_PORTS 2'h3
`define PORT_W 2
`define WORD_W 4
`define WORDS_PER_PORT 16
`define MEM_ADDR_W 6
`define MEM_DEPTH 64
`define NUM_CNT 30
`define LEN_W 14
`define BYTES_W 16
`define WRAP_PORT_LSB 30

// Frame length limits in bytes
`define SHORT_EVENT_LEN 14'h000a
`define MIN_FRAME_LEN 14'h0040
`define BIN_127_LEN 14'h007f
`define BIN_255_LEN 14'h00ff
`define BIN_511_LEN 14'h01ff
`define BIN_1023_LEN 14'h03ff
`define MAX_UNTAG_LEN 14'h05ee
`define MAX_TAG_LEN 14'h05f2

// Wrap bit of each counter
`define C_TX_BYTES 0
`define C_TX_UCAST 1
`define C_TX_FAIL 2
`define C_TX_PAUSE 3
`define C_TX_NUCAST 4
`define C_RX_BYTES 5
`define C_RX_FRAMES 6
`define C_RX_ALL_BYTES 7
`define C_RX_ALL_FRAMES 8
`define C_RX_PAUSE 9
`define C_RX_MCAST 10
`define C_RX_BCAST 11
`define C_BIN_64 12
`define C_JABBER 13
`define C_BIN_65 14
`define C_OVERSIZE 15
`define C_BIN_128 16
`define C_BIN_256 17
`define C_BIN_512 18
`define C_BIN_1024 19
`define C_FRAGMENT 20
`define C_ALIGN 21
`define C_UNDERSIZE 22
`define C_CRC 23
`define C_SHORT 24
`define C_COLLISION 25
`define C_DROP 26
`define C_FILTER 27
`define C_RESERVED 28
`define C_LATE_COL 29

// Location of each counter, entry i for wrap bit i: word, low bit, width
`define CNT_WORD_TBL 120'hfffeeddcccbbaa9988776654322110
`define CNT_LSB_TBL 240'h181000100010001810001000100018001800100018000000001000180000
`define CNT_WID_TBL 240'h080810101010100808101010101008180818101008182020201010081820
// Counters that advance by the byte count instead of by one
`define BYTE_CNT_MASK 30'h000000a1

`endif

// File: logic/stats_mem.v
// Counter memory: one write port, one read port with registered read data.
// Contents are not reset; the owner sweeps it clear after reset.
`timescale 1ns/1ps
`include "stats_defines.vh"

module stats_mem (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Write port
  input wire we_in,
  input wire [`MEM_ADDR_W-1:0] waddr_in,
  input wire [31:0] wdata_in,
  // Read port
  input wire re_in,
  input wire [`MEM_ADDR_W-1:0] raddr_in,
  output wire [31:0] rdata_out
);

  reg [31:0] mem [0:`MEM_DEPTH-1];
  reg [31:0] rdata_reg;

  always @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 32'h00000000;
    end else if (re_in) begin
      rdata_reg <= mem[raddr_in];
    end
  end

  assign rdata_out = rdata_reg;

endmodule // stats_mem

// File: logic/stats_word_update.v
// Combinational update of one counter word: adds the increments of every
// counter packed into that word and reports which of them rolled over.
`timescale 1ns/1ps
`include "stats_defines.vh"

module stats_word_update (
  // Word being updated
  input wire [`WORD_W-1:0] word_in,
  input wire [31:0] old_in,
  // Increments
  input wire [`NUM_CNT-1:0] hit_in,
  input wire [`BYTES_W-1:0] bytes_in,
  // Result
  output wire [31:0] new_out,
  output wire [`NUM_CNT-1:0] wrap_out
);

  localparam [119:0] WORD_TBL = `CNT_WORD_TBL;
  localparam [239:0] LSB_TBL = `CNT_LSB_TBL;
  localparam [239:0] WID_TBL = `CNT_WID_TBL;
  localparam [`NUM_CNT-1:0] BYTE_MASK = `BYTE_CNT_MASK;

  wire [31:0] acc [0:`NUM_CNT];
  assign acc[0] = 32'h00000000;

  genvar i;
  generate
    for (i = 0; i < `NUM_CNT; i = i + 1) begin : g_cnt
      localparam [3:0] CW = WORD_TBL[i*4+:4];
      localparam [7:0] LSB = LSB_TBL[i*8+:8];
      localparam [7:0] WID = WID_TBL[i*8+:8];
      localparam [32:0] ONE_SH = 33'h000000001 << WID;
      localparam [31:0] MASK = ONE_SH[31:0] - 32'h00000001;
      wire sel = (word_in == CW);
      wire [31:0] field = (old_in >> LSB) & MASK;
      wire [31:0] inc = (sel && hit_in[i]) ? (BYTE_MASK[i] ? {16'h0000, bytes_in} : 32'h00000001) : 32'h00000000;
      wire [32:0] sum = {1'b0, field} + {1'b0, inc};
      // Roll over rather than saturate; the carry out is the wrap flag
      assign wrap_out[i] = sel && hit_in[i] && (sum > {1'b0, MASK});
      assign acc[i+1] = acc[i] | (sel ? ((sum[31:0] & MASK) << LSB) : 32'h00000000);
    end
  endgenerate

  assign new_out = acc[`NUM_CNT];

endmodule // stats_word_update

// File: logic/port_statistics_counters.v
// Per-port statistics counters: classifies MAC and queue manager events,
// updates the packed counter words and reports wraps to the CPU side.
// Assumes event sources hold valid until ready, and the CPU command block
// drains wrap reports; all inputs are synchronous to clk_in.
`timescale 1ns/1ps
`include "stats_defines.vh"

module port_statistics_counters (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // MAC receive frame summary
  input wire rx_valid_in,
  output wire rx_ready_out,
  input wire [`PORT_W-1:0] rx_port_in,
  input wire [`LEN_W-1:0] rx_len_in,
  input wire rx_fcs_err_in,
  input wire rx_align_err_in,
  input wire rx_coll_in,
  input wire rx_tagged_in,
  input wire rx_limit_en_in,
  input wire [`LEN_W-1:0] rx_limit_in,
  input wire rx_bcast_in,
  input wire rx_mcast_in,
  input wire rx_pause_in,
  input wire rx_drop_in,
  // MAC transmit frame summary
  input wire tx_valid_in,
  output wire tx_ready_out,
  input wire [`PORT_W-1:0] tx_port_in,
  input wire [`LEN_W-1:0] tx_len_in,
  input wire tx_ucast_in,
  input wire tx_pause_in,
  input wire tx_underrun_in,
  input wire tx_late_col_in,
  input wire tx_col16_in,
  input wire tx_coll_in,
  // Queue manager filtering event
  input wire filt_valid_in,
  output wire filt_ready_out,
  input wire [`PORT_W-1:0] filt_port_in,
  // CPU counter read
  input wire hrd_valid_in,
  output wire hrd_ready_out,
  input wire [`PORT_W-1:0] hrd_port_in,
  input wire [`WORD_W-1:0] hrd_word_in,
  output wire hrd_data_valid_out,
  output wire [31:0] hrd_data_out,
  // Wrap report to the CPU command block
  output wire wrap_valid_out,
  input wire wrap_ready_in,
  output wire [63:0] wrap_data_out
);

  localparam [1:0] ST_CLEAR = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_WALK = 2'h2;
  localparam [1:0] ST_REPORT = 2'h3;
  localparam [4:0] WALK_END = 5'h10;
  localparam [3:0] LAST_WORD = 4'hf;
  localparam [6:0] CLEAR_LAST = 7'h3f;
  localparam [`PORT_W-1:0] PORT_LIMIT = `NUM_PORTS;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [6:0] clr_idx_reg;
  reg [`PORT_W-1:0] port_reg;
  reg [`NUM_CNT-1:0] hit_reg;
  reg [`BYTES_W-1:0] bytes_reg;
  reg [4:0] rd_idx_reg;
  reg [`WORD_W-1:0] wr_idx_reg;
  reg dv_reg;
  reg [`NUM_CNT-1:0] wrap_acc_reg;
  reg [63:0] wrap_data_reg;
  reg hrd_dv_reg;

  // Source selection, host reads first so software is never locked out
  wire idle = (state_reg == ST_IDLE);
  wire hrd_take = idle && hrd_valid_in;
  wire rx_take = idle && !hrd_valid_in && rx_valid_in;
  wire tx_take = idle && !hrd_valid_in && !rx_valid_in && tx_valid_in;
  wire filt_take = idle && !hrd_valid_in && !rx_valid_in && !tx_valid_in && filt_valid_in;
  wire ev_take = rx_take || tx_take || filt_take;

  assign hrd_ready_out = idle;
  assign rx_ready_out = idle && !hrd_valid_in;
  assign tx_ready_out = idle && !hrd_valid_in && !rx_valid_in;
  assign filt_ready_out = idle && !hrd_valid_in && !rx_valid_in && !tx_valid_in;

  // Receive classification
  wire [`LEN_W-1:0] max_len = rx_limit_en_in ? rx_limit_in :
                              (rx_tagged_in ? `MAX_TAG_LEN : `MAX_UNTAG_LEN);
  // Length is the whole frame as the MAC counted it, FCS included
  wire len_short = rx_len_in < `SHORT_EVENT_LEN;
  wire len_runt = rx_len_in < `MIN_FRAME_LEN;
  wire len_long = rx_len_in > max_len;
  wire len_ok = !len_runt && !len_long;
  wire rx_good = len_ok && !rx_fcs_err_in && !rx_align_err_in && !rx_coll_in;
  reg [`NUM_CNT-1:0] rx_hit;
  reg [`NUM_CNT-1:0] tx_hit;
  reg [`NUM_CNT-1:0] ev_hit;
  reg [`BYTES_W-1:0] ev_bytes;
  reg [`PORT_W-1:0] ev_port;

  always @* begin
    rx_hit = {`NUM_CNT{1'b0}};
    rx_hit[`C_RX_BYTES] = 1'b1;
    rx_hit[`C_RX_FRAMES] = 1'b1;
    rx_hit[`C_RX_ALL_BYTES] = 1'b1;
    rx_hit[`C_RX_ALL_FRAMES] = 1'b1;
    rx_hit[`C_RX_PAUSE] = rx_pause_in;
    rx_hit[`C_RX_MCAST] = rx_good && rx_mcast_in && !rx_bcast_in;
    rx_hit[`C_RX_BCAST] = rx_good && rx_bcast_in;
    // Size bins ignore FCS state on purpose
    rx_hit[`C_BIN_64] = !rx_coll_in && (rx_len_in == `MIN_FRAME_LEN);
    rx_hit[`C_JABBER] = !rx_coll_in && len_long && rx_fcs_err_in;
    rx_hit[`C_BIN_65] = !rx_coll_in && (rx_len_in > `MIN_FRAME_LEN) && (rx_len_in <= `BIN_127_LEN);
    rx_hit[`C_OVERSIZE] = !rx_coll_in && len_long;
    rx_hit[`C_BIN_128] = !rx_coll_in && (rx_len_in > `BIN_127_LEN) && (rx_len_in <= `BIN_255_LEN);
    rx_hit[`C_BIN_256] = !rx_coll_in && (rx_len_in > `BIN_255_LEN) && (rx_len_in <= `BIN_511_LEN);
    rx_hit[`C_BIN_512] = !rx_coll_in && (rx_len_in > `BIN_511_LEN) && (rx_len_in <= `BIN_1023_LEN);
    rx_hit[`C_BIN_1024] = !rx_coll_in && (rx_len_in > `BIN_1023_LEN) && !len_long;
    rx_hit[`C_FRAGMENT] = !rx_coll_in && len_runt && rx_fcs_err_in;
    rx_hit[`C_ALIGN] = !rx_coll_in && len_ok && rx_align_err_in;
    rx_hit[`C_UNDERSIZE] = !rx_coll_in && len_runt && !rx_fcs_err_in && !rx_align_err_in;
    rx_hit[`C_CRC] = !rx_coll_in && len_ok && rx_fcs_err_in && !rx_align_err_in;
    rx_hit[`C_SHORT] = !rx_coll_in && len_short;
    rx_hit[`C_DROP] = rx_drop_in;
  end

  always @* begin
    tx_hit = {`NUM_CNT{1'b0}};
    tx_hit[`C_TX_BYTES] = 1'b1;
    tx_hit[`C_TX_UCAST] = tx_ucast_in;
    tx_hit[`C_TX_FAIL] = tx_underrun_in || tx_late_col_in || tx_col16_in;
    tx_hit[`C_TX_PAUSE] = tx_pause_in;
    tx_hit[`C_TX_NUCAST] = !tx_ucast_in;
    tx_hit[`C_COLLISION] = tx_coll_in;
    tx_hit[`C_LATE_COL] = tx_late_col_in;
  end

  // Filtering comes only from the queue manager port
  always @* begin
    ev_hit = {`NUM_CNT{1'b0}};
    // Byte counters take the 14-bit length zero-extended
    ev_bytes = {`BYTES_W{1'b0}};
    ev_port = filt_port_in;
    if (rx_take) begin
      ev_hit = rx_hit;
      ev_bytes = {2'b00, rx_len_in};
      ev_port = rx_port_in;
    end else if (tx_take) begin
      ev_hit = tx_hit;
      ev_bytes = {2'b00, tx_len_in};
      ev_port = tx_port_in;
    end else begin
      ev_hit[`C_FILTER] = 1'b1;
    end
  end

  // Port 3 has no counter words; its events are taken and discarded
  wire ev_port_ok = (ev_port < PORT_LIMIT);

  // Memory walk: read word k while writing back word k-1
  wire rd_walk = (state_reg == ST_WALK) && (rd_idx_reg < WALK_END);
  wire clearing = (state_reg == ST_CLEAR);
  wire [31:0] mem_rdata;
  wire [31:0] upd_word;
  wire [`NUM_CNT-1:0] upd_wrap;
  wire walk_wr = (state_reg == ST_WALK) && dv_reg;
  wire walk_done = walk_wr && (wr_idx_reg == LAST_WORD);
  // Wraps of all sixteen words are ORed; one report covers the whole event
  wire [`NUM_CNT-1:0] wrap_all = wrap_acc_reg | upd_wrap;

  wire mem_re = hrd_take || rd_walk;
  wire [`MEM_ADDR_W-1:0] mem_raddr = hrd_take ? {hrd_port_in, hrd_word_in} : {port_reg, rd_idx_reg[3:0]};
  // Counter memory has no reset, so the sweep writes zeros to all 64 words
  wire mem_we = clearing || walk_wr;
  wire [`MEM_ADDR_W-1:0] mem_waddr = clearing ? clr_idx_reg[5:0] : {port_reg, wr_idx_reg};
  wire [31:0] mem_wdata = clearing ? 32'h00000000 : upd_word;

  stats_mem u_mem (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .re_in(mem_re),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  // Update works on the word fetched one cycle earlier, indexed by wr_idx_reg
  stats_word_update u_upd (
    .word_in(wr_idx_reg),
    .old_in(mem_rdata),
    .hit_in(hit_reg),
    .bytes_in(bytes_reg),
    .new_out(upd_word),
    .wrap_out(upd_wrap)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_CLEAR: begin
        if (clr_idx_reg == CLEAR_LAST) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // A walk starts only for a port that owns counter words
        if (ev_take && ev_port_ok) begin
          state_next = ST_WALK;
        end
      end
      ST_WALK: begin
        // Readies stay low through all 17 walk cycles
        if (walk_done) begin
          state_next = (wrap_all != {`NUM_CNT{1'b0}}) ? ST_REPORT : ST_IDLE;
        end
      end
      ST_REPORT: begin
        // Next event waits so no wrap flag is overwritten unseen
        if (wrap_ready_in) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_CLEAR;
      end
    endcase
  end

  // Host reads share the memory read port with the walk, so they are only
  // taken in idle; a read waits out a walk and any pending wrap report
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_CLEAR;
      clr_idx_reg <= 7'h00;
      port_reg <= {`PORT_W{1'b0}};
      hit_reg <= {`NUM_CNT{1'b0}};
      bytes_reg <= {`BYTES_W{1'b0}};
      rd_idx_reg <= 5'h00;
      wr_idx_reg <= 4'h0;
      dv_reg <= 1'b0;
      wrap_acc_reg <= {`NUM_CNT{1'b0}};
      wrap_data_reg <= 64'h0000000000000000;
      hrd_dv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hrd_dv_reg <= hrd_take;
      if (clearing) begin
        clr_idx_reg <= clr_idx_reg + 7'h01;
      end
      if (ev_take) begin
        port_reg <= ev_port;
        hit_reg <= ev_hit;
        bytes_reg <= ev_bytes;
        rd_idx_reg <= 5'h00;
        dv_reg <= 1'b0;
        wrap_acc_reg <= {`NUM_CNT{1'b0}};
      end else if (state_reg == ST_WALK) begin
        dv_reg <= rd_walk;
        wr_idx_reg <= rd_idx_reg[3:0];
        if (rd_walk) begin
          rd_idx_reg <= rd_idx_reg + 5'h01;
        end
        if (walk_wr) begin
          wrap_acc_reg <= wrap_all;
        end
        if (walk_done) begin
          wrap_data_reg <= {32'h00000000, port_reg, wrap_all};
        end
      end
    end
  end

  assign wrap_valid_out = (state_reg == ST_REPORT);
  assign wrap_data_out = wrap_data_reg;
  // Read data is the memory output register, valid only with the pulse
  assign hrd_data_valid_out = hrd_dv_reg;
  assign hrd_data_out = mem_rdata;

endmodule // port_statistics_counters

// File: tb/stats_checker_assertions.sv
// Port timing checker for the statistics counter block.
// Sees only top-level ports; one clock domain, bound below.
`timescale 1ns/1ps
`include "stats_defines.vh"
module stats_checker (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Handshakes
  input wire rx_valid_in,
  input wire rx_ready_out,
  input wire [`PORT_W-1:0] rx_port_in,
  input wire tx_ready_out,
  input wire filt_ready_out,
  input wire hrd_valid_in,
  input wire hrd_ready_out,
  input wire hrd_data_valid_out,
  // Wrap report
  input wire wrap_valid_out,
  input wire wrap_ready_in,
  input wire [63:0] wrap_data_out
);
  reg [6:0] clr_cnt_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Cycles since reset release, saturating
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in)
      clr_cnt_reg <= 7'h00;
    else if (clr_cnt_reg != 7'h7f)
      clr_cnt_reg <= clr_cnt_reg + 7'h01;
  end
  sequence s_busy8;
    (!rx_ready_out && !tx_ready_out && !filt_ready_out && !hrd_ready_out) [*8];
  endsequence
  a_clear_sweep: assert property (clr_cnt_reg < 7'h40 |-> !hrd_ready_out && !rx_ready_out)
    else $error("ready during clear sweep");
  a_read_answer: assert property (hrd_valid_in && hrd_ready_out |=> hrd_data_valid_out)
    else $error("read not answered");
  a_answer_cause: assert property (hrd_data_valid_out |-> $past(hrd_valid_in && hrd_ready_out))
    else $error("answer without read");
  a_read_first: assert property (hrd_valid_in |-> !rx_ready_out)
    else $error("event beat a read");
  a_event_busy: assert property (rx_valid_in && rx_ready_out && rx_port_in != 2'h3 |=>
    s_busy8 ##1 s_busy8 ##1 !hrd_ready_out ##1 (hrd_ready_out || wrap_valid_out))
    else $error("event walk length wrong");
  a_wrap_hold: assert property (wrap_valid_out && !wrap_ready_in |=> wrap_valid_out && $stable(wrap_data_out))
    else $error("wrap report not held");
  a_wrap_done: assert property (wrap_valid_out && wrap_ready_in |=> !wrap_valid_out)
    else $error("wrap report not dropped");
  a_wrap_form: assert property (wrap_valid_out |-> wrap_data_out[63:32] == 32'h0 && wrap_data_out[29:0] != 30'h0
    && !wrap_data_out[28] && wrap_data_out[31:30] != 2'h3)
    else $error("wrap report format");
  a_wrap_stall: assert property (wrap_valid_out |-> !hrd_ready_out && !filt_ready_out)
    else $error("ready while reporting");
endmodule // stats_checker

bind port_statistics_counters stats_checker chk (.clk_in, .nrst_in, .rx_valid_in, .rx_ready_out, .rx_port_in,
  .tx_ready_out, .filt_ready_out, .hrd_valid_in, .hrd_ready_out, .hrd_data_valid_out, .wrap_valid_out,
  .wrap_ready_in, .wrap_data_out);

// File: tb/host_cpu_model.sv
// Host CPU model: reads counter words and takes wrap reports.
// Assumes a single clock; requests change only at falling edges.
`timescale 1ns/1ps
module host_cpu_model (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Counter read
  output reg hrd_valid_out = 1'b0,
  output reg [1:0] hrd_port_out = 2'h3,
  output reg [3:0] hrd_word_out = 4'hf,
  input wire hrd_ready_in,
  input wire dv_in,
  input wire [31:0] data_in,
  // Wrap report intake
  input wire wrap_valid_in,
  input wire [63:0] wrap_data_in,
  output reg wrap_ready_out = 1'b0,
  input wire [3:0] stall_in,
  output reg [63:0] last_out,
  output reg [7:0] count_out
);
  reg [3:0] wait_reg;
  // Slow acceptance keeps the report standing for a while
  always @(negedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wrap_ready_out <= 1'b0;
      wait_reg <= 4'h0;
    end else if (wrap_ready_out) begin
      wrap_ready_out <= 1'b0;
    end else if (wrap_valid_in) begin
      wrap_ready_out <= wait_reg == stall_in;
      wait_reg <= (wait_reg == stall_in) ? 4'h0 : wait_reg + 4'h1;
    end
  end
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_out <= 64'h0;
      count_out <= 8'h00;
    end else if (wrap_valid_in && wrap_ready_out) begin
      last_out <= wrap_data_in;
      count_out <= count_out + 8'h01;
    end
  end
  task read_word(input [1:0] p, input [3:0] w, output [31:0] d);
    integer n;
    begin
      n = 0;
      @(negedge clk_in);
      hrd_valid_out = 1'b1;
      hrd_port_out = p;
      hrd_word_out = w;
      #1;
      while (hrd_ready_in !== 1'b1 && n < 200) begin
        @(negedge clk_in);
        #1;
        n = n + 1;
      end
      @(negedge clk_in);
      d = (dv_in === 1'b1) ? data_in : 32'hx;
      hrd_valid_out = 1'b0;
      // Released address does not keep its last value
      hrd_port_out = ~p;
      hrd_word_out = ~w;
    end
  endtask
endmodule // host_cpu_model

// File: tb/tb.sv
// Self-checking bench for the statistics counter block.
// Host model reads words; MAC and queue manager events come from here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
  bad_count = bad_count + 1; $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg rx_valid_in = 1'b0;
  reg tx_valid_in = 1'b0;
  reg filt_valid_in = 1'b0;
  reg rx_fcs_err_in = 1'b0;
  reg rx_tagged_in = 1'b0;
  reg rx_limit_en_in = 1'b0;
  reg [13:0] rx_limit_in = 14'h0000;
  reg [1:0] rx_port_in = 2'h0;
  reg [1:0] tx_port_in = 2'h0;
  reg [1:0] filt_port_in = 2'h0;
  reg [13:0] rx_len_in = 14'h0000;
  reg [13:0] tx_len_in = 14'h0000;
  reg [5:0] rx_flags = 6'h00;
  reg [5:0] tx_flags = 6'h00;
  reg [3:0] stall = 4'h0;
  wire rx_ready_out, tx_ready_out, filt_ready_out, hrd_valid_in, hrd_ready_out, hrd_data_valid_out;
  wire wrap_valid_out, wrap_ready_in;
  wire [1:0] hrd_port_in;
  wire [3:0] hrd_word_in;
  wire [31:0] hrd_data_out;
  wire [63:0] wrap_data_out, last_wrap;
  wire [7:0] wrap_count;
  integer bad_count = 0;
  integer compares = 0;
  integer i;
  // Size limit is driven so the port bound of the top bin is exercised too
  port_statistics_counters dut (.clk_in, .nrst_in, .rx_valid_in, .rx_ready_out, .rx_port_in, .rx_len_in,
    .rx_fcs_err_in, .rx_align_err_in(rx_flags[5]), .rx_coll_in(rx_flags[4]), .rx_tagged_in,
    .rx_limit_en_in, .rx_limit_in, .rx_bcast_in(rx_flags[3]), .rx_mcast_in(rx_flags[2]),
    .rx_pause_in(rx_flags[1]), .rx_drop_in(rx_flags[0]), .tx_valid_in, .tx_ready_out, .tx_port_in, .tx_len_in,
    .tx_ucast_in(tx_flags[5]), .tx_pause_in(tx_flags[4]), .tx_underrun_in(tx_flags[3]),
    .tx_late_col_in(tx_flags[2]), .tx_col16_in(tx_flags[1]), .tx_coll_in(tx_flags[0]), .filt_valid_in,
    .filt_ready_out, .filt_port_in, .hrd_valid_in, .hrd_ready_out, .hrd_port_in, .hrd_word_in,
    .hrd_data_valid_out, .hrd_data_out, .wrap_valid_out, .wrap_ready_in, .wrap_data_out);
  host_cpu_model host (.clk_in, .nrst_in, .hrd_valid_out(hrd_valid_in), .hrd_port_out(hrd_port_in),
    .hrd_word_out(hrd_word_in), .hrd_ready_in(hrd_ready_out), .dv_in(hrd_data_valid_out), .data_in(hrd_data_out),
    .wrap_valid_in(wrap_valid_out), .wrap_data_in(wrap_data_out), .wrap_ready_out(wrap_ready_in),
    .stall_in(stall), .last_out(last_wrap), .count_out(wrap_count));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // Returns just before the edge that will take the request
  task wait_rdy(input integer k);
    integer n;
    begin
      n = 0;
      #1;
      while ((k == 0 ? hrd_ready_out : k == 1 ? rx_ready_out : k == 2 ? tx_ready_out : filt_ready_out) !== 1'b1
        && n < 400) begin
        @(negedge clk_in);
        #1;
        n = n + 1;
      end
    end
  endtask
  task ev(input integer k, input [1:0] p, input [13:0] len, input [1:0] ft, input [5:0] f);
    begin
      @(negedge clk_in);
      if (k == 1) begin
        {rx_port_in, rx_len_in, rx_fcs_err_in, rx_tagged_in, rx_flags} = {p, len, ft, f};
        rx_valid_in = 1'b1;
      end else if (k == 2) begin
        {tx_port_in, tx_len_in, tx_flags} = {p, len, f};
        tx_valid_in = 1'b1;
      end else begin
        filt_port_in = p;
        filt_valid_in = 1'b1;
      end
      wait_rdy(k);
      @(negedge clk_in);
      {rx_valid_in, tx_valid_in, filt_valid_in} = 3'b000;
      wait_rdy(0);
    end
  endtask
  task chk_word(input [1:0] p, input [3:0] w, input [31:0] e);
    reg [31:0] d;
    begin
      host.read_word(p, w, d);
      `CHK("counter word", e, d)
    end
  endtask
  task bin(input [13:0] len, input [1:0] ft, input [5:0] f, input [3:0] w, input [31:0] e);
    begin
      ev(1, 2'h2, len, ft, f);
      chk_word(2'h2, w, e);
    end
  endtask
  task t_reset;
    for (i = 0; i < 16; i = i + 1)
      chk_word(2'h0, i[3:0], 32'h0);
  endtask
  task t_rx;
    begin
      ev(1, 2'h1, 14'd64, 2'b00, 6'h08);
      ev(1, 2'h1, 14'd64, 2'b00, 6'h07);
      ev(1, 2'h1, 14'd64, 2'b10, 6'h10);
      chk_word(2'h1, 4'h3, 32'hc0);
      chk_word(2'h1, 4'h4, 32'h3);
      chk_word(2'h1, 4'h5, 32'hc0);
      chk_word(2'h1, 4'h6, 32'h01000003);
      chk_word(2'h1, 4'h7, 32'h00010001);
      chk_word(2'h1, 4'h8, 32'h2);
      chk_word(2'h1, 4'he, 32'h00010000);
      chk_word(2'h1, 4'hd, 32'h0);
    end
  endtask
  task t_bins;
    begin
      bin(14'd64, 2'b00, 6'h00, 4'h8, 32'h1);
      bin(14'd100, 2'b00, 6'h00, 4'h9, 32'h1);
      bin(14'd200, 2'b00, 6'h20, 4'ha, 32'h1);
      bin(14'd300, 2'b00, 6'h00, 4'ha, 32'h00010001);
      bin(14'd600, 2'b00, 6'h00, 4'hb, 32'h1);
      bin(14'd1100, 2'b00, 6'h00, 4'hb, 32'h00010001);
      bin(14'd1520, 2'b01, 6'h00, 4'hb, 32'h00020001);
      bin(14'd1530, 2'b10, 6'h00, 4'h9, 32'h01000001);
      bin(14'd30, 2'b10, 6'h00, 4'hc, 32'h00010001);
      bin(14'd5, 2'b00, 6'h00, 4'hd, 32'h00010000);
      bin(14'd64, 2'b10, 6'h00, 4'hd, 32'h00010001);
      chk_word(2'h2, 4'h8, 32'h01000002);
    end
  endtask
  task t_tx;
    begin
      ev(2, 2'h2, 14'd100, 2'b00, 6'h04);
      ev(2, 2'h2, 14'd50, 2'b00, 6'h33);
      ev(2, 2'h2, 14'd20, 2'b00, 6'h28);
      chk_word(2'h2, 4'h0, 32'haa);
      chk_word(2'h2, 4'h1, 32'h03000002);
      chk_word(2'h2, 4'h2, 32'h00010001);
      chk_word(2'h2, 4'he, 32'h1);
      chk_word(2'h2, 4'hf, 32'h01000000);
    end
  endtask
  task t_filt;
    begin
      ev(3, 2'h3, 14'd0, 2'b00, 6'h00);
      ev(3, 2'h0, 14'd0, 2'b00, 6'h00);
      ev(3, 2'h0, 14'd0, 2'b00, 6'h00);
      chk_word(2'h0, 4'hf, 32'h2);
      chk_word(2'h1, 4'hf, 32'h0);
    end
  endtask
  // 256 send failures roll the 8-bit field over once
  task t_wrap;
    begin
      stall = 4'h5;
      for (i = 0; i < 256; i = i + 1)
        ev(2, 2'h1, 14'd1, 2'b00, 6'h28);
      `CHK("wrap report", {32'h0, 2'h1, 30'h4}, last_wrap)
      `CHK("wrap count", 8'h01, wrap_count)
      chk_word(2'h1, 4'h1, 32'h00000100);
      chk_word(2'h1, 4'h0, 32'h00000100);
    end
  endtask
  // Port size limit overrides the tag bound of the top bin
  task t_limit;
    begin
      rx_limit_in = 14'h0400;
      rx_limit_en_in = 1'b1;
      ev(1, 2'h0, 14'h0406, 2'b01, 6'h00);
      ev(1, 2'h0, 14'h0400, 2'b00, 6'h00);
      rx_limit_en_in = 1'b0;
      chk_word(2'h0, 4'h9, 32'h01000000);
      chk_word(2'h0, 4'hb, 32'h00010000);
    end
  endtask
  // Mid-run reset must clear the counters and the last wrap report data left on wrap_data_out
  task t_rerun;
    begin
      @(negedge clk_in);
      nrst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      nrst_in = 1'b1;
      `CHK("wrap data", 64'h0000000000000000, wrap_data_out)
      chk_word(2'h1, 4'h1, 32'h00000000);
      chk_word(2'h1, 4'h0, 32'h00000000);
    end
  endtask
  task stop_test;
    begin
      if (bad_count == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    t_reset;
    t_rx;
    t_bins;
    t_limit;
    t_tx;
    t_filt;
    t_wrap;
    t_rerun;
    stop_test;
  end
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    stop_test;
  end
endmodule // tb
